// file: core/pls_pkg.sv
// package: register map, field layout, reset values and timing counts for the pulse/config bank
package pls_pkg;
  // clock and timing
  localparam int unsigned CLK_HZ           = 40000000;  // mclk rate
  localparam int unsigned PULSE_DEF_MS     = 80;        // default active-low pulse width
  localparam int unsigned SETTLE_MS_C0     = 64;        // settle code 0
  localparam int unsigned SETTLE_MS_C1     = 128;       // settle code 1
  localparam int unsigned SETTLE_MS_C2     = 256;       // settle code 2
  localparam int unsigned PULSE_DEF_CYC    = PULSE_DEF_MS * (CLK_HZ / 1000);
  localparam int unsigned SETTLE_C0_CYC    = SETTLE_MS_C0 * (CLK_HZ / 1000);
  localparam int unsigned SETTLE_C1_CYC    = SETTLE_MS_C1 * (CLK_HZ / 1000);
  localparam int unsigned SETTLE_C2_CYC    = SETTLE_MS_C2 * (CLK_HZ / 1000);
  localparam int unsigned CNT_W            = 24;        // wide enough for 256 ms

  // register addresses (spi word addresses)
  localparam logic [11:0] ADDR_PULSE_LT    = 12'h425;   // pulse_low_time_config
  localparam logic [11:0] ADDR_TEMP_TRIM   = 12'h471;   // temperature_trim
  localparam logic [11:0] ADDR_GEN_CFG1    = 12'h481;   // general_config_one

  // pulse_low_time_config fields
  localparam int unsigned LT_B_OVR_BIT     = 20;
  localparam int unsigned LT_A_OVR_BIT     = 19;
  localparam int unsigned LT_CNT_W         = 19;
  localparam logic [31:0] LT_RST           = 32'h0000_0000;
  localparam logic [31:0] LT_WMASK         = 32'h001f_ffff;

  // general_config_one fields
  localparam int unsigned C1_EXTERNAL_REFERENCE_SELECT_BIT   = 15;
  localparam int unsigned C1_IRQ_MODE_BIT  = 14;
  localparam int unsigned C1_BURST_BIT     = 11;
  localparam int unsigned C1_SETTLE_LSB    = 8;
  localparam int unsigned C1_ACC_CLR_BIT   = 5;
  localparam logic [15:0] C1_RST           = 16'h0300;
  localparam logic [15:0] C1_WMASK         = 16'hcb00;  // stored bits only: 15, 14, 11, 9:8

  // spi framing
  localparam int unsigned CMD_BITS         = 16;
  localparam int unsigned CMD_RD_BIT       = 3;
  localparam int unsigned CRC_BITS         = 16;
  localparam logic [15:0] CRC_POLY         = 16'h1021;
  localparam logic [15:0] CRC_INIT         = 16'hffff;

  // spi state machine
  typedef enum logic [1:0] {
    SPI_CMD  = 2'b00,
    SPI_DATA = 2'b01,
    SPI_CRC  = 2'b10,
    SPI_DONE = 2'b11
  } pls_spi_state_type;
endpackage

// file: core/pls_pulse_gen.sv
// one energy pulse output: active-low stretcher with fixed, half-period or programmable width
`timescale 1ns/10ps
module pls_pulse_gen
  import pls_pkg::*;
#(
  parameter int unsigned DEF_CYC = PULSE_DEF_CYC  // default low time in mclk cycles
) (
  input  wire logic                mclk,       // clock
  input  wire logic                rst,        // async reset, active high
  input  wire logic                fire,       // one-cycle pulse request
  input  wire logic                override,   // use programmed width
  input  wire logic [LT_CNT_W-1:0] low_count,  // programmed width in cycles
  output logic                     pin_n_q     // active-low pulse output
);
  logic [CNT_W-1:0] width_q;   // cycles left low
  logic [CNT_W-1:0] period_q;  // cycles since last request, saturating
  logic [CNT_W-1:0] def_w;     // default width for this request

  // fixed 80 ms below 6.25 Hz, else half the last period keeps the output toggling
  always_comb begin
    if (period_q >= CNT_W'(2 * DEF_CYC)) begin
      def_w = CNT_W'(DEF_CYC);
    end else begin
      def_w = {1'b0, period_q[CNT_W-1:1]};
    end
  end

  // period measurement between requests
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      period_q <= '1;
    end else if (fire) begin
      period_q <= '0;
    end else if (period_q != '1) begin
      period_q <= period_q + CNT_W'(1);
    end
  end

  // low-time counter; a new request restarts the width
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      width_q <= '0;
      pin_n_q <= 1'b1;
    end else if (fire) begin
      if (override) begin
        width_q <= (low_count == '0) ? CNT_W'(1) : CNT_W'(low_count);
      end else begin
        width_q <= (def_w == '0) ? CNT_W'(1) : def_w;
      end
      pin_n_q <= 1'b0;
    end else if (width_q > CNT_W'(1)) begin
      width_q <= width_q - CNT_W'(1);
    end else begin
      width_q <= '0;
      pin_n_q <= 1'b1;
    end
  end
endmodule  // pls_pulse_gen

// file: core/pls_bank.sv
// top: spi register bank, pulse outputs, settle gate and sag/surge interrupt style
`timescale 1ns/10ps
module pls_bank
  import pls_pkg::*;
#(
  parameter int unsigned PULSE_CYC = PULSE_DEF_CYC,  // default pulse low time
  parameter int unsigned SET0_CYC  = SETTLE_C0_CYC,  // settle code 0
  parameter int unsigned SET1_CYC  = SETTLE_C1_CYC,  // settle code 1
  parameter int unsigned SET2_CYC  = SETTLE_C2_CYC   // settle code 2
) (
  input  wire logic        mclk,                 // 40 mhz clock
  input  wire logic        rst,                  // async reset, active high
  input  wire logic        spi_sclk,             // spi clock pin
  input  wire logic        spi_ss_n,             // spi select, active low
  input  wire logic        spi_mosi,             // spi data in
  output logic             spi_miso,             // spi data out
  output logic             spi_miso_oe,          // miso drive enable
  input  wire logic [31:0] temp_trim_fuse,       // factory trim word
  input  wire logic        metering_restart,     // pulse: restart settling
  input  wire logic [23:0] energy_a_val,         // energy increment a
  input  wire logic [23:0] energy_b_val,         // energy increment b
  input  wire logic        energy_valid,         // pulse: increments valid
  input  wire logic [15:0] pulse_divider_count,  // quanta per output pulse
  input  wire logic        line_cycle,           // pulse: one line cycle
  input  wire logic        sag_active,           // sag condition level
  input  wire logic        surge_active,         // surge condition level
  input  wire logic [15:0] sag_cycle_count,      // repeat period for sag
  input  wire logic [15:0] surge_cycle_count,    // repeat period for surge
  output logic             energy_pulse_out_a_n, // pulse output a, active low
  output logic             energy_pulse_out_b_n, // pulse output b, active low
  output logic             external_reference_select, // reference select level
  output logic             sag_irq,              // pulse: sag interrupt
  output logic             surge_irq,            // pulse: surge interrupt
  output logic             accum_enabled         // accumulation running
);
  // ---------------- registers ----------------
  logic [31:0] lt_cfg_q;     // pulse_low_time_config
  logic [31:0] trim_q;       // temperature_trim copy
  logic [15:0] cfg1_q;       // general_config_one stored bits
  logic        acc_clr_q;    // pulse_accum_clear, self clearing
  logic        wr_en;        // write strobe from spi
  logic [11:0] wr_addr;      // write address
  logic [31:0] wr_data;      // write data

  // ---------------- spi pin synchronisers ----------------
  logic [1:0] sclk_s, ss_s, mosi_s;  // two-flop chains
  logic       sclk_d;                // delayed synced clock
  logic       rise, fall, sel;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sclk_s <= 2'b11;
      ss_s   <= 2'b11;
      mosi_s <= 2'b00;
      sclk_d <= 1'b1;
    end else begin
      sclk_s <= {sclk_s[0], spi_sclk};
      ss_s   <= {ss_s[0], spi_ss_n};
      mosi_s <= {mosi_s[0], spi_mosi};
      sclk_d <= sclk_s[1];
    end
  end
  assign sel  = ~ss_s[1];
  assign rise = sel & sclk_s[1] & ~sclk_d;  // host sampling edge
  assign fall = sel & ~sclk_s[1] & sclk_d;  // our launch edge

  // ---------------- read mux ----------------
  // reserved bits come back zero through the masks
  function automatic logic [31:0] rd_word(input logic [11:0] a);
    case (a)
      ADDR_PULSE_LT:  rd_word = lt_cfg_q & LT_WMASK;
      ADDR_TEMP_TRIM: rd_word = trim_q;
      ADDR_GEN_CFG1:  rd_word = {cfg1_q & C1_WMASK, 16'h0000};
      default:        rd_word = 32'h0000_0000;
    endcase
  endfunction

  // word length: config one is 16 bits, the rest 32
  function automatic logic [5:0] len_of(input logic [11:0] a);
    len_of = (a == ADDR_GEN_CFG1) ? 6'd16 : 6'd32;
  endfunction

  // ---------------- spi engine ----------------
  pls_spi_state_type st_q;
  logic [31:0] in_q;       // receive shifter
  logic [31:0] out_q;      // transmit shifter, msb first
  logic [5:0]  cnt_q;      // bits in current field
  logic [11:0] addr_q;     // current address
  logic        rd_q;       // current frame is a read
  logic [15:0] crc_q;      // crc over sent data bits
  logic [31:0] in_next;

  assign in_next = {in_q[30:0], mosi_s[1]};

  // frame sequencing on host sampling edges; select high aborts the frame
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q   <= SPI_CMD;
      in_q   <= '0;
      cnt_q  <= '0;
      addr_q <= '0;
      rd_q   <= 1'b0;
    end else if (!sel) begin
      st_q  <= SPI_CMD;
      cnt_q <= '0;
    end else if (rise) begin
      in_q  <= in_next;
      cnt_q <= cnt_q + 6'd1;
      case (st_q)
        SPI_CMD: begin
          if (cnt_q == 6'(CMD_BITS - 1)) begin
            addr_q <= in_next[15:4];
            rd_q   <= in_next[CMD_RD_BIT];
            st_q   <= SPI_DATA;
            cnt_q  <= '0;
          end
        end
        SPI_DATA: begin
          if (cnt_q == len_of(addr_q) - 6'd1) begin
            cnt_q <= '0;
            if (!rd_q) begin
              st_q <= SPI_DONE;  // one word per write frame
            end else if (cfg1_q[C1_BURST_BIT]) begin
              addr_q <= addr_q + 12'd1;
            end else begin
              st_q <= SPI_CRC;
            end
          end
        end
        SPI_CRC: begin
          if (cnt_q == 6'(CRC_BITS - 1)) begin
            st_q <= SPI_DONE;
          end
        end
        default: st_q <= SPI_DONE;  // extra clocks ignored
      endcase
    end
  end

  // write strobe when a write word completes
  always_comb begin
    wr_en   = rise && st_q == SPI_DATA && !rd_q && cnt_q == len_of(addr_q) - 6'd1;
    wr_addr = addr_q;
    wr_data = in_next;
  end

  // transmit shifter: loaded on the sampling edge, bits launched on falling edges
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      out_q       <= '0;
      crc_q       <= CRC_INIT;
      spi_miso    <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else begin
      spi_miso_oe <= sel;
      if (!sel) begin
        out_q    <= '0;
        spi_miso <= 1'b0;
      end else if (rise && rd_q && st_q == SPI_DATA
                   && cnt_q == len_of(addr_q) - 6'd1) begin
        if (cfg1_q[C1_BURST_BIT]) begin
          out_q <= rd_word(addr_q + 12'd1);  // next word, no crc
          crc_q <= CRC_INIT;
        end else begin
          out_q <= {crc_q, 16'h0000};  // crc trails the word
        end
      end else if (rise && st_q == SPI_CMD && cnt_q == 6'(CMD_BITS - 1)) begin
        out_q <= in_next[CMD_RD_BIT] ? rd_word(in_next[15:4]) : 32'h0000_0000;
        crc_q <= CRC_INIT;
      end else if (fall) begin
        spi_miso <= out_q[31];
        out_q    <= {out_q[30:0], 1'b0};
        if (st_q == SPI_DATA && rd_q) begin
          crc_q <= {crc_q[14:0], 1'b0} ^ ((crc_q[15] ^ out_q[31]) ? CRC_POLY : 16'h0000);
        end
      end
    end
  end

  // ---------------- register writes ----------------
  // pulse width configuration
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lt_cfg_q <= LT_RST;
    end else if (wr_en && wr_addr == ADDR_PULSE_LT) begin
      lt_cfg_q <= wr_data & LT_WMASK;
    end
  end

  // general config; the clear bit is a one-cycle strobe, never stored
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cfg1_q    <= C1_RST;
      acc_clr_q <= 1'b0;
    end else begin
      acc_clr_q <= wr_en && wr_addr == ADDR_GEN_CFG1 && wr_data[C1_ACC_CLR_BIT];
      if (wr_en && wr_addr == ADDR_GEN_CFG1) begin
        cfg1_q <= wr_data[15:0] & C1_WMASK;
      end
    end
  end

  // trim follows the fuse word; software cannot write it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      trim_q <= '0;
    end else begin
      trim_q <= temp_trim_fuse;
    end
  end

  // reference select is a plain level for the analog side
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      external_reference_select <= 1'b0;
    end else begin
      external_reference_select <= cfg1_q[C1_EXTERNAL_REFERENCE_SELECT_BIT];
    end
  end

  // ---------------- settle gate ----------------
  logic [CNT_W-1:0] settle_q;  // cycles left before accumulation
  logic [1:0]       set_code;
  assign set_code = cfg1_q[C1_SETTLE_LSB +: 2];

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      settle_q      <= '0;  // reset code 3 means no wait
      accum_enabled <= 1'b0;
    end else begin
      if (metering_restart || acc_clr_q) begin
        case (set_code)
          2'b00:   settle_q <= CNT_W'(SET0_CYC);
          2'b01:   settle_q <= CNT_W'(SET1_CYC);
          2'b10:   settle_q <= CNT_W'(SET2_CYC);
          default: settle_q <= '0;
        endcase
      end else if (settle_q != '0) begin
        settle_q <= settle_q - CNT_W'(1);
      end
      accum_enabled <= (settle_q == '0) && !metering_restart && !acc_clr_q;
    end
  end

  // ---------------- digital-to-frequency conversion ----------------
  logic [24:0] acc_q [2];   // energy accumulators, carry out = one quantum
  logic [15:0] div_q [2];   // divider counters
  logic [1:0]  fire_q;      // pulse requests to the stretchers
  logic [23:0] inc  [2];
  logic [1:0]  ovr;
  assign inc[0] = energy_a_val;
  assign inc[1] = energy_b_val;
  assign ovr    = {lt_cfg_q[LT_B_OVR_BIT], lt_cfg_q[LT_A_OVR_BIT]};

  for (genvar i = 0; i < 2; i++) begin : g_ch
    logic [24:0] sum;
    assign sum = {1'b0, acc_q[i][23:0]} + {1'b0, inc[i]};

    // accumulate and divide; clear wins over everything
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        acc_q[i]  <= '0;
        div_q[i]  <= '0;
        fire_q[i] <= 1'b0;
      end else begin
        fire_q[i] <= 1'b0;
        if (acc_clr_q) begin
          acc_q[i] <= '0;
          div_q[i] <= '0;
        end else if (energy_valid && accum_enabled) begin
          acc_q[i] <= {1'b0, sum[23:0]};
          if (sum[24]) begin
            if (div_q[i] + 16'd1 >= pulse_divider_count) begin
              div_q[i]  <= '0;
              fire_q[i] <= 1'b1;
            end else begin
              div_q[i] <= div_q[i] + 16'd1;
            end
          end
        end
      end
    end
  end

  pls_pulse_gen #(.DEF_CYC(PULSE_CYC)) u_pulse_a (
    .mclk      (mclk),
    .rst       (rst),
    .fire      (fire_q[0]),
    .override  (ovr[0]),
    .low_count (lt_cfg_q[LT_CNT_W-1:0]),
    .pin_n_q   (energy_pulse_out_a_n)
  );

  pls_pulse_gen #(.DEF_CYC(PULSE_CYC)) u_pulse_b (
    .mclk      (mclk),
    .rst       (rst),
    .fire      (fire_q[1]),
    .override  (ovr[1]),
    .low_count (lt_cfg_q[LT_CNT_W-1:0]),
    .pin_n_q   (energy_pulse_out_b_n)
  );

  // ---------------- sag / surge interrupt style ----------------
  logic [1:0]  cond, cond_d;  // current and last condition level
  logic [15:0] cyc_q [2];     // line cycles since last interrupt
  logic [15:0] per  [2];
  logic [1:0]  irq_q;
  assign cond   = {surge_active, sag_active};
  assign per[0] = sag_cycle_count;
  assign per[1] = surge_cycle_count;

  // style 0 repeats while the condition lasts; style 1 marks entry and exit only
  for (genvar j = 0; j < 2; j++) begin : g_irq
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        cond_d[j] <= 1'b0;
        cyc_q[j]  <= '0;
        irq_q[j]  <= 1'b0;
      end else begin
        cond_d[j] <= cond[j];
        irq_q[j]  <= 1'b0;
        if (cfg1_q[C1_IRQ_MODE_BIT]) begin
          irq_q[j] <= cond[j] ^ cond_d[j];
          cyc_q[j] <= '0;
        end else if (!cond[j]) begin
          cyc_q[j] <= '0;
        end else if (line_cycle) begin
          if (cyc_q[j] + 16'd1 >= per[j]) begin
            cyc_q[j] <= '0;
            irq_q[j] <= 1'b1;
          end else begin
            cyc_q[j] <= cyc_q[j] + 16'd1;
          end
        end
      end
    end
  end
  assign sag_irq   = irq_q[0];
  assign surge_irq = irq_q[1];
endmodule  // pls_bank

// file: dv/pls_bank_asserts.sv
// checker: port-level assertions for the pulse/config bank
`timescale 1ns/10ps
module pls_bank_asserts
  import pls_pkg::*;
#(
  parameter int unsigned SET2_CYC = SETTLE_C2_CYC  // longest settle wait
) (
  input wire logic mclk,                       // clock
  input wire logic rst,                        // async reset, active high
  input wire logic spi_ss_n,                   // spi select, active low
  input wire logic spi_miso_oe,                // miso drive enable
  input wire logic energy_valid,               // increments valid
  input wire logic line_cycle,                 // line cycle pulse
  input wire logic sag_active,                 // sag level
  input wire logic surge_active,               // surge level
  input wire logic energy_pulse_out_a_n,       // pulse output a
  input wire logic energy_pulse_out_b_n,       // pulse output b
  input wire logic external_reference_select,  // reference select
  input wire logic sag_irq,                    // sag interrupt
  input wire logic surge_irq,                  // surge interrupt
  input wire logic accum_enabled               // accumulation running
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  logic [15:0] idle_q;  // cycles with select released
  logic [23:0] hold_q;  // cycles with accumulation held off

  // select idle counter, saturating so it never wraps back into range
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) idle_q <= '0;
    else if (!spi_ss_n) idle_q <= '0;
    else if (idle_q != 16'hffff) idle_q <= idle_q + 16'h1;
  end

  // settle hold counter
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) hold_q <= '0;
    else if (accum_enabled) hold_q <= '0;
    else if (hold_q != 24'hffffff) hold_q <= hold_q + 24'h1;
  end

  sequence s_sel_idle;
    spi_ss_n [*4];
  endsequence
  sequence s_sel_live;
    !spi_ss_n [*4];
  endsequence

  property p_rst_quiet;
    disable iff (1'b0) rst |-> energy_pulse_out_a_n && energy_pulse_out_b_n && !sag_irq
      && !surge_irq && !spi_miso_oe && !accum_enabled && !external_reference_select;
  endproperty

  a_reset_quiet:
    assert property (p_rst_quiet) else $error("outputs not quiet in reset");
  a_oe_idle_off:
    assert property (s_sel_idle |=> !spi_miso_oe) else $error("miso driven while idle");
  a_oe_live_on:
    assert property (s_sel_live |=> spi_miso_oe) else $error("miso not driven in frame");
  a_pulse_a_cause:
    assert property ($fell(energy_pulse_out_a_n) |-> $past(energy_valid, 2)
      && $past(accum_enabled, 2)) else $error("pulse a without quantum");
  a_pulse_b_cause:
    assert property ($fell(energy_pulse_out_b_n) |-> $past(energy_valid, 2)
      && $past(accum_enabled, 2)) else $error("pulse b without quantum");
  a_sag_irq_cause:
    assert property (sag_irq |-> $past(sag_active) != $past(sag_active, 2)
      || $past(line_cycle) || $past(line_cycle, 2) || $past(line_cycle, 3))
      else $error("sag irq without cause");
  a_surge_irq_cause:
    assert property (surge_irq |-> $past(surge_active) != $past(surge_active, 2)
      || $past(line_cycle) || $past(line_cycle, 2) || $past(line_cycle, 3))
      else $error("surge irq without cause");
  a_irq_single_cycle:
    assert property (sag_irq || surge_irq |=> !sag_irq && !surge_irq)
      else $error("irq longer than one cycle");
  a_ref_write_only:
    assert property (!$stable(external_reference_select) |-> idle_q < 16'd8)
      else $error("reference select moved outside a frame");
  a_settle_bound:
    assert property (hold_q <= 24'(SET2_CYC + 4)) else $error("settle wait too long");
endmodule // pls_bank_asserts

bind pls_bank pls_bank_asserts #(.SET2_CYC(SET2_CYC)) pls_bank_asserts_i (
  .mclk, .rst, .spi_ss_n, .spi_miso_oe, .energy_valid, .line_cycle, .sag_active,
  .surge_active, .energy_pulse_out_a_n, .energy_pulse_out_b_n, .external_reference_select,
  .sag_irq, .surge_irq, .accum_enabled);

// file: dv/pls_host_model.sv
// spi host model: mode 3 frames launched from the mclk domain
`timescale 1ns/10ps
module pls_host_model #(
  parameter int HALF = 6  // mclk cycles per sclk half period
) (
  input  wire logic mclk,      // bench clock
  output logic      spi_sclk,  // spi clock, idle high
  output logic      spi_ss_n,  // select, active low
  output logic      spi_mosi,  // host data out
  input  wire logic spi_miso   // device data out
);
  // idle bus at time zero
  initial begin
    spi_sclk = 1'b1;
    spi_ss_n = 1'b1;
    spi_mosi = 1'b0;
  end

  // 16 command bits then n data bits; miso taken at each rising sclk of the n data bits
  task automatic xfer(input logic [15:0] cmd, input int n, input logic [63:0] wd,
                      output logic [63:0] rd);
    logic b;
    rd = '0;
    @(posedge mclk) spi_ss_n <= 1'b0;
    repeat (HALF) @(posedge mclk);
    for (int i = 0; i < 16 + n; i++) begin
      b = (i < 16) ? cmd[15 - i] : wd[n - 1 - (i - 16)];
      spi_sclk <= 1'b0;
      spi_mosi <= b;
      repeat (HALF) @(posedge mclk);
      spi_sclk <= 1'b1;
      if (i >= 16) rd = {rd[62:0], spi_miso};
      repeat (HALF) @(posedge mclk);
    end
    spi_ss_n <= 1'b1;
    spi_mosi <= ~spi_mosi;  // released line must not look stale
    repeat (2 * HALF) @(posedge mclk);
  endtask
endmodule // pls_host_model

// file: dv/pls_bank_tb_top.sv
// testbench: scenarios for the pulse/config bank and its spi host
`timescale 1ns/10ps
module pls_bank_tb_top;
  import pls_pkg::*;
  localparam int unsigned PC = 100;                  // shortened default pulse
  localparam int          SC [4] = '{50, 70, 90, 0}; // settle wait per code
  logic        mclk, rst, spi_sclk, spi_ss_n, spi_mosi, spi_miso, spi_miso_oe;
  logic [31:0] temp_trim_fuse;                       // factory trim word
  logic        metering_restart, energy_valid, line_cycle, sag_active, surge_active;
  logic [23:0] energy_a_val, energy_b_val;           // energy increments
  logic [15:0] pulse_divider_count, sag_cycle_count, surge_cycle_count;
  logic        energy_pulse_out_a_n, energy_pulse_out_b_n, external_reference_select;
  logic        sag_irq, surge_irq, accum_enabled;    // observed outputs
  int          failures, total_checks;               // report counters
  logic [63:0] rd;                                   // bits of the last frame

  pls_bank #(.PULSE_CYC(PC), .SET0_CYC(50), .SET1_CYC(70), .SET2_CYC(90)) pls_bank_i (
    .mclk, .rst, .spi_sclk, .spi_ss_n, .spi_mosi, .spi_miso, .spi_miso_oe,
    .temp_trim_fuse, .metering_restart, .energy_a_val, .energy_b_val, .energy_valid,
    .pulse_divider_count, .line_cycle, .sag_active, .surge_active, .sag_cycle_count,
    .surge_cycle_count, .energy_pulse_out_a_n, .energy_pulse_out_b_n,
    .external_reference_select, .sag_irq, .surge_irq, .accum_enabled);
  pls_host_model pls_host_model_i (.mclk, .spi_sclk, .spi_ss_n, .spi_mosi, .spi_miso);

  initial mclk = 1'b0;
  always #12.5 mclk = ~mclk;

  // verdict and end of run
  task automatic stop_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // counts are bench-side ints, checked against a window
  task automatic chk_cnt(input int got, input int lo, input int hi);
    total_checks++;
    if (got < lo || got > hi) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, lo);
    end
  endtask
  // crc over the data bits, msb first
  function automatic logic [15:0] crc16(input logic [31:0] d, input int n);
    logic [15:0] c;
    c = CRC_INIT;
    for (int i = n - 1; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? CRC_POLY : 16'h0);
    return c;
  endfunction
  task automatic wr(input logic [11:0] a, input logic [31:0] v, input int n);
    pls_host_model_i.xfer({a, 4'h0}, n, {32'h0, v}, rd);
  endtask
  task automatic rdr(input logic [11:0] a, input int n);
    pls_host_model_i.xfer({a, 4'h8}, n, 64'h0, rd);
  endtask
  // two half-scale increments carry one quantum
  task automatic quantum(input int k);
    repeat (k) begin
      @(posedge mclk) energy_valid <= 1'b1;
      @(posedge mclk) energy_valid <= 1'b0;
    end
  endtask
  // low cycles of each output over a fixed window
  task automatic lows(input int win, output int wa, output int wb);
    wa = 0;
    wb = 0;
    repeat (win) begin
      @(posedge mclk);
      wa += (energy_pulse_out_a_n === 1'b0);
      wb += (energy_pulse_out_b_n === 1'b0);
    end
  endtask
  // irqs seen over n line cycles spaced four clocks apart
  task automatic irqs(input int n, output int s, output int u);
    s = 0;
    u = 0;
    for (int k = 0; k < 4 * n; k++) begin
      @(posedge mclk) line_cycle <= (k % 4 == 0);
      s += (sag_irq === 1'b1);
      u += (surge_irq === 1'b1);
    end
  endtask

  task automatic t_regs();
    rdr(ADDR_PULSE_LT, 48);
    chk_val(rd, {LT_RST, crc16(LT_RST, 32)});
    rdr(ADDR_GEN_CFG1, 32);
    chk_val(rd, {C1_RST, crc16({16'h0, C1_RST}, 16)});
    @(posedge mclk) temp_trim_fuse <= 32'h5a3c_0f96;
    wr(ADDR_TEMP_TRIM, 32'hffff_ffff, 32);
    rdr(ADDR_TEMP_TRIM, 48);
    chk_val(rd[47:32], 16'h5a3c);
    chk_val(rd[31:16], 16'h0f96);
    rdr(12'h400, 48);
    chk_val(rd, {32'h0, crc16(32'h0, 32)});
    $display("t_regs done");
  endtask
  task automatic t_width();
    int wa, wb;
    repeat (3) begin
      quantum(2);
      lows(300, wa, wb);
    end
    chk_cnt(wa, PC, PC);
    chk_cnt(wb, PC, PC);
    wr(ADDR_PULSE_LT, 32'hfff8_0025, 32);
    rdr(ADDR_PULSE_LT, 48);
    chk_val(rd[47:16], 32'h0018_0025);
    quantum(2);
    lows(300, wa, wb);
    chk_cnt(wa, 37, 37);
    chk_cnt(wb, 37, 37);
    wr(ADDR_PULSE_LT, 32'h0010_0025, 32);
    quantum(2);
    lows(300, wa, wb);
    chk_cnt(wa, PC, PC);
    chk_cnt(wb, 37, 37);
    $display("t_width done");
  endtask
  task automatic t_cfg();
    wr(ADDR_GEN_CFG1, 32'hffff, 16);
    chk_val(external_reference_select, 1'b1);
    rdr(ADDR_GEN_CFG1, 48);
    chk_val(rd, {16'h0, 16'hcb00, 32'h0});
    wr(ADDR_GEN_CFG1, 32'h0300, 16);
    chk_val(external_reference_select, 1'b0);
    $display("t_cfg done");
  endtask
  task automatic t_settle();
    int n;
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_GEN_CFG1, {22'h0, c[1:0], 8'h0}, 16);
      @(posedge mclk) metering_restart <= 1'b1;
      @(posedge mclk) metering_restart <= 1'b0;
      n = 0;
      repeat (120) begin
        @(posedge mclk);
        n += (accum_enabled === 1'b0);
      end
      chk_cnt(n, (c == 3) ? 0 : SC[c] - 1, SC[c] + 2);
    end
    $display("t_settle done");
  endtask
  task automatic t_clear();
    int wa, wb;
    @(posedge mclk) pulse_divider_count <= 16'h0002;
    quantum(3);
    wr(ADDR_GEN_CFG1, 32'h0320, 16);
    quantum(3);
    lows(40, wa, wb);
    chk_cnt(wa + wb, 0, 0);
    quantum(2);
    lows(150, wa, wb);
    chk_cnt(wa, 1, PC);
    $display("t_clear done");
  endtask
  task automatic t_irq();
    int s, u;
    wr(ADDR_GEN_CFG1, 32'h4300, 16);
    @(posedge mclk) {sag_active, surge_active} <= 2'b11;
    irqs(6, s, u);
    chk_cnt(s + 8 * u, 9, 9);
    @(posedge mclk) {sag_active, surge_active} <= 2'b00;
    irqs(6, s, u);
    chk_cnt(s + 8 * u, 9, 9);
    wr(ADDR_GEN_CFG1, 32'h0300, 16);
    @(posedge mclk) {sag_active, surge_active} <= 2'b11;
    irqs(6, s, u);
    chk_cnt(s + 8 * u, 26, 26);
    @(posedge mclk) {sag_active, surge_active} <= 2'b00;
    irqs(3, s, u);
    chk_cnt(s + u, 0, 0);
    $display("t_irq done");
  endtask

  initial begin
    rst = 1'b1;
    {failures, total_checks} = '0;
    {metering_restart, energy_valid, line_cycle, sag_active, surge_active} = '0;
    {energy_a_val, energy_b_val} = {24'h800000, 24'h800000};
    temp_trim_fuse = 32'h0;
    pulse_divider_count = 16'h0001;
    {sag_cycle_count, surge_cycle_count} = {16'h0003, 16'h0002};
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    t_width();
    t_cfg();
    t_settle();
    t_clear();
    t_irq();
    stop_test();
  end
endmodule // pls_bank_tb_top
